// File: pkg/siu_pkg.sv
/*
  siu_pkg: constants, states and carriers for the system integration unit
  (break handling, low-power modes, reset cause capture, pending status).
  Assumes one clock (SYS_CLK), which also stands in for the crystal clock,
  and a byte-wide register port with a 16-bit address.
*/
package siu_pkg;

  // register byte addresses
  localparam logic [15:0] OFF_BRK_STATUS = 16'hFE00; // break_wait_exit_status
  localparam logic [15:0] OFF_RST_CAUSE = 16'hFE01;  // last_reset_cause
  localparam logic [15:0] OFF_BRK_CTRL = 16'hFE03;   // break_flag_clear_control
  localparam logic [15:0] OFF_IRQ_LOW = 16'hFE04;    // sources 6..1
  localparam logic [15:0] OFF_IRQ_MID = 16'hFE05;    // irq_pending_mid
  localparam logic [15:0] OFF_IRQ_UPPER = 16'hFE06;  // irq_pending_upper
  localparam logic [15:0] OFF_IRQ_TOP = 16'hFE07;    // irq_pending_top

  // field positions
  localparam int BIT_BREAK_EXITED_WAIT = 1;  // in break status
  localparam int BIT_BREAK_CLEAR_ENABLE = 7; // in break control
  localparam int BIT_POR = 7;                // reset cause bits
  localparam int BIT_PIN = 6;
  localparam int BIT_WDOG = 5;
  localparam int BIT_BAD_OPCODE = 4;
  localparam int BIT_BAD_ADDR = 3; // opcode fetches only
  localparam int BIT_MON = 2;
  localparam int BIT_LOW_VOLT = 1;

  // reset values
  localparam logic [7:0] RST_CAUSE_POR = 8'h80; // power-on leaves only POR
  localparam logic [7:0] BYTE_ZERO = 8'h00;

  // cycle counts, in crystal clock cycles
  localparam logic [12:0] STOP_LONG_CYC = 13'h1000;  // 4096
  localparam logic [12:0] STOP_SHORT_CYC = 13'h0020; // 32
  localparam logic [12:0] PIN_SAMPLE_CYC = 13'h0020; // 32 after release
  localparam logic [12:0] PIN_DRIVE_CYC = 13'h0020;  // pin held low
  localparam logic [12:0] CNT_ONE = 13'h0001;
  localparam logic [12:0] CNT_ZERO = 13'h0000;

  // sequencer states
  typedef enum logic [2:0] {
    MODE_RUN, MODE_WAIT, MODE_STOP, MODE_RECOVER, MODE_RST_DRIVE,
    MODE_RST_SAMPLE
  } siu_mode_e;

  // internal reset requests, one-cycle pulses from their sources
  typedef struct packed {
    logic wdog;    // watchdog timeout
    logic bad_opcode; // illegal opcode
    logic bad_address; // illegal address on opcode fetch
    logic mon; // monitor mode entry reset
    logic low_volt; // low-voltage detect
  } siu_rst_src_s;

  // whole state of the unit
  typedef struct packed {
    siu_mode_e mode;     // sequencer state
    logic [12:0] cnt;    // shared recovery / reset counter
    logic [24:1] pend;   // pending request bits
    logic [7:0] cause;   // last reset cause
    logic brk_woke; // break ended wait
    logic clr_en; // break clear enable
    logic brk_d;         // break request, last cycle
    logic brk_state;     // break state active
    logic [7:0] rdata;   // read answer
    logic cpu_en;        // cpu clock enable
    logic per_en;        // peripheral clock enable
    logic xtal_en;       // crystal/bus clock generator enable
    logic clr_imask;     // pulse: clear cpu global mask
    logic stack;         // pulse: start interrupt stacking
    logic soft_irq; // pulse: force software-interrupt vector
    logic pin_oe_n;      // reset pin drive, low while driving
    logic sys_rst;       // system reset level
    logic allow;         // status flag clearing allowed
    logic wdog_run;      // watchdog clock running
  } siu_state_s;

endpackage : siu_pkg

// File: verilog/siu_core.sv
/*
  siu_core: break entry, status flag protection, wait/stop sequencing with
  stop recovery timing, reset pin drive and sampling, reset cause register
  and the pending-request status registers.
  Assumes SYS_CLK is the crystal clock, all inputs are synchronous to it,
  the cpu and peripherals honour the enable and pulse outputs, and the
  register master never asserts read and write strobes together.
*/
// Implementation choice: strobed register access.
module siu_core
  import siu_pkg::*;
(
  input wire logic SYS_CLK,
  input wire logic ARST_N,
  input wire logic [15:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  input wire logic [24:1] IRQ_FLAGS,
  input wire logic [24:1] IRQ_ENABLES,
  input wire logic BRK_REQ,
  input wire logic WAIT_EXEC,
  input wire logic STOP_EXEC,
  input wire logic EMU_MODE,
  input wire logic WDOG_DISABLE,
  input wire logic SHORT_STOP_RECOVERY,
  input wire siu_rst_src_s RST_SRC,
  input wire logic MON_VEC_BLANK,
  input wire logic IRQ_PIN_HIGH,
  input wire logic RST_PIN_IN,
  output logic RST_PIN_OUT,
  output logic RST_PIN_OE_N,
  output logic SYS_RESET,
  output logic CPU_CLK_EN,
  output logic PERIPH_CLK_EN,
  output logic XTAL_CLK_EN,
  output logic CLEAR_IMASK,
  output logic STACK_START,
  output logic VECTOR_SOFT_IRQ,
  output logic BREAK_STATE,
  output logic FLAG_CLEAR_ALLOW,
  output logic WDOG_RUN
);

  siu_state_s s_r;   // registered state
  siu_state_s s_nxt; // next state

  // decodes the register address into a read value
  function automatic logic [7:0] reg_read(input logic [15:0] a,
                                          input siu_state_s s,
                                          input logic emu);
    logic [7:0] v;
    v = BYTE_ZERO;
    unique case (a)
      OFF_IRQ_LOW: v = {s.pend[6:1], 2'h0};
      OFF_IRQ_MID: v = s.pend[14:7];
      OFF_IRQ_UPPER: v = s.pend[22:15];
      OFF_IRQ_TOP: v = {6'h00, s.pend[24:23]};
      OFF_RST_CAUSE: v = s.cause;
      OFF_BRK_CTRL: v[BIT_BREAK_CLEAR_ENABLE] = s.clr_en;
      // outside emulation the break status reads as zero
      OFF_BRK_STATUS: v[BIT_BREAK_EXITED_WAIT] = emu & s.brk_woke;
      default: v = BYTE_ZERO; // unmapped addresses read zero
    endcase
    return v;
  endfunction : reg_read

  logic any_rst;      // some internal reset request this cycle
  logic pin_rst;      // pin pulled low by the outside, not by us
  logic any_pend;     // some enabled request pending
  logic brk_rise;     // break request edge
  logic cnt_done;     // counter one below its target, last cycle of the count
  logic [12:0] cnt_target; // target of the running count

  // next-state logic: one process for every field
  always_comb
  begin
    s_nxt = s_r;
    any_rst = |RST_SRC;
    // pin low while we are not driving it is an external reset
    pin_rst = ~RST_PIN_IN & s_r.pin_oe_n;
    any_pend = |s_r.pend;
    brk_rise = BRK_REQ & ~s_r.brk_d;
    // pulses default low
    s_nxt.clr_imask = 1'h0;
    s_nxt.stack = 1'h0;
    s_nxt.soft_irq = 1'h0;
    s_nxt.brk_d = BRK_REQ;
    // pending bits follow the sources every cycle
    s_nxt.pend = IRQ_FLAGS & IRQ_ENABLES;
    // target depends on state and on the short-recovery choice
    unique case (s_r.mode)
      MODE_RECOVER: cnt_target = SHORT_STOP_RECOVERY ?
                                 STOP_SHORT_CYC : STOP_LONG_CYC;
      MODE_RST_DRIVE: cnt_target = PIN_DRIVE_CYC;
      default: cnt_target = PIN_SAMPLE_CYC;
    endcase
    cnt_done = (s_r.cnt == cnt_target - CNT_ONE);

    // register reads: answer one cycle later, cause clears on read
    s_nxt.rdata = RD ? reg_read(ADDR, s_r, EMU_MODE) : BYTE_ZERO;
    if (RD && ADDR == OFF_RST_CAUSE)
    begin
      s_nxt.cause = BYTE_ZERO;
    end
    // writes: control bits take them, break status takes only a zero; pending status and cause ignore
    if (WR && ADDR == OFF_BRK_CTRL)
    begin
      s_nxt.clr_en = WDATA[BIT_BREAK_CLEAR_ENABLE];
    end
    // writing zero clears the break-exit flag, in emulation only
    if (WR && ADDR == OFF_BRK_STATUS && EMU_MODE &&
        !WDATA[BIT_BREAK_EXITED_WAIT])
    begin
      s_nxt.brk_woke = 1'h0;
    end
    // other write addresses have no effect

    // break state follows the break module's level
    s_nxt.brk_state = BRK_REQ;

    // sequencer; reset sources are checked before anything else
    if (any_rst || pin_rst)
    begin
      // every reset has one shared top level; no arbitration
      s_nxt.mode = MODE_RST_DRIVE;
      s_nxt.cnt = CNT_ZERO;
      // every source adds its own bit, mon only under the condition below; sources landing together all show
      s_nxt.cause[BIT_WDOG] |= RST_SRC.wdog;
      s_nxt.cause[BIT_BAD_OPCODE] |= RST_SRC.bad_opcode;
      s_nxt.cause[BIT_BAD_ADDR] |= RST_SRC.bad_address;
      s_nxt.cause[BIT_LOW_VOLT] |= RST_SRC.low_volt;
      // monitor entry counts only with a blank vector and irq high
      s_nxt.cause[BIT_MON] |= RST_SRC.mon & MON_VEC_BLANK &
                              IRQ_PIN_HIGH;
      s_nxt.cause[BIT_PIN] |= pin_rst;
    end
    else
    begin
      unique case (s_r.mode)
        MODE_RUN:
        begin
          if (brk_rise)
          begin
            s_nxt.soft_irq = 1'h1;
          end
          else if (STOP_EXEC)
          begin
            s_nxt.mode = MODE_STOP;
            s_nxt.cnt = CNT_ZERO;
            s_nxt.clr_imask = 1'h1;
          end
          else if (WAIT_EXEC)
          begin
            s_nxt.mode = MODE_WAIT;
            s_nxt.clr_imask = 1'h1;
          end
        end
        MODE_WAIT:
        begin
          // break ends wait and leaves a note for the handler
          if (brk_rise)
          begin
            s_nxt.mode = MODE_RUN;
            s_nxt.soft_irq = 1'h1;
            s_nxt.brk_woke = 1'h1;
          end
          else if (any_pend)
          begin
            s_nxt.mode = MODE_RUN;
            s_nxt.stack = 1'h1;
          end
        end
        MODE_STOP:
        begin
          // counter stays cleared until recovery starts
          s_nxt.cnt = CNT_ZERO;
          if (any_pend)
          begin
            s_nxt.mode = MODE_RECOVER;
          end
        end
        MODE_RECOVER:
        begin
          // stacking waits for the whole recovery period
          if (cnt_done)
          begin
            s_nxt.mode = MODE_RUN;
            s_nxt.cnt = CNT_ZERO;
            s_nxt.stack = 1'h1;
          end
          else
          begin
            s_nxt.cnt = s_r.cnt + CNT_ONE;
          end
        end
        MODE_RST_DRIVE:
        begin
          // pin held low, then released for sampling
          if (cnt_done)
          begin
            s_nxt.mode = MODE_RST_SAMPLE;
            s_nxt.cnt = CNT_ZERO;
          end
          else
          begin
            s_nxt.cnt = s_r.cnt + CNT_ONE;
          end
        end
        MODE_RST_SAMPLE:
        begin
          // pin sampled once, the set adds to the other cause bits
          if (cnt_done)
          begin
            s_nxt.mode = MODE_RUN;
            s_nxt.cnt = CNT_ZERO;
            if (!RST_PIN_IN)
            begin
              s_nxt.cause[BIT_PIN] = 1'h1;
            end
          end
          else
          begin
            s_nxt.cnt = s_r.cnt + CNT_ONE;
          end
        end
      endcase
    end

    // outputs are decoded from the next state so they leave flops
    s_nxt.sys_rst = (s_nxt.mode == MODE_RST_DRIVE) ||
                    (s_nxt.mode == MODE_RST_SAMPLE);
    s_nxt.pin_oe_n = (s_nxt.mode != MODE_RST_DRIVE);
    s_nxt.cpu_en = (s_nxt.mode == MODE_RUN);
    // peripherals run in wait, stop in stop and recovery
    s_nxt.per_en = (s_nxt.mode != MODE_STOP) &&
                   (s_nxt.mode != MODE_RECOVER);
    s_nxt.xtal_en = (s_nxt.mode != MODE_STOP);
    s_nxt.wdog_run = !WDOG_DISABLE && s_nxt.per_en;
    // clearing is blocked in break unless enabled; a blocked clear is
    // simply never performed, so a set flag stays set and a
    // half-done two-step clear completes on a step two issued after break ends
    s_nxt.allow = !s_nxt.brk_state || s_nxt.clr_en;
  end

  // the only state register; power-on leaves just the POR cause
  always_ff @(posedge SYS_CLK or negedge ARST_N)
  begin
    if (!ARST_N)
    begin
      s_r <= '{mode: MODE_RST_DRIVE, cnt: CNT_ZERO, pend: '0,
               cause: RST_CAUSE_POR, brk_woke: 1'h0, clr_en: 1'h0,
               brk_d: 1'h0, brk_state: 1'h0, rdata: BYTE_ZERO,
               cpu_en: 1'h0, per_en: 1'h1, xtal_en: 1'h1, clr_imask: 1'h0,
               stack: 1'h0, soft_irq: 1'h0, pin_oe_n: 1'h0, sys_rst: 1'h1,
               allow: 1'h1, wdog_run: 1'h0};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ports straight from the state register, all but the tied-low RST_PIN_OUT
  assign RDATA = s_r.rdata;
  assign RST_PIN_OUT = 1'h0; // open drain: only ever pulls low
  assign RST_PIN_OE_N = s_r.pin_oe_n;
  assign SYS_RESET = s_r.sys_rst;
  assign CPU_CLK_EN = s_r.cpu_en;
  assign PERIPH_CLK_EN = s_r.per_en;
  assign XTAL_CLK_EN = s_r.xtal_en;
  assign CLEAR_IMASK = s_r.clr_imask;
  assign STACK_START = s_r.stack;
  assign VECTOR_SOFT_IRQ = s_r.soft_irq;
  assign BREAK_STATE = s_r.brk_state;
  assign FLAG_CLEAR_ALLOW = s_r.allow;
  assign WDOG_RUN = s_r.wdog_run;

  // checks
  default clocking cb @(posedge SYS_CLK); endclocking
  default disable iff (!ARST_N);

  property p_mid_read;
    (RD && ADDR == OFF_IRQ_MID) |=> RDATA == $past(s_r.pend[14:7]);
  endproperty
  a_mid_read: assert property (p_mid_read)
    else $error("mid status read wrong");

  property p_upper_read;
    (RD && ADDR == OFF_IRQ_UPPER) |=> RDATA == $past(s_r.pend[22:15]);
  endproperty
  a_upper_read: assert property (p_upper_read)
    else $error("upper status read wrong");

  property p_top_zero;
    (RD && ADDR == OFF_IRQ_TOP) |=> RDATA[7:2] == 6'h00;
  endproperty
  a_top_zero: assert property (p_top_zero)
    else $error("top status high bits not zero");

  property p_low_zero;
    (RD && ADDR == OFF_IRQ_LOW) |=> RDATA[1:0] == 2'h0;
  endproperty
  a_low_zero: assert property (p_low_zero)
    else $error("low status bits 1..0 not zero");

  property p_rst_first;
    (|RST_SRC) |=> SYS_RESET && !STACK_START && !RST_PIN_OE_N;
  endproperty
  a_rst_first: assert property (p_rst_first)
    else $error("reset did not win");

  property p_wait_wake;
    (s_r.mode == MODE_WAIT && |s_r.pend && !(|RST_SRC) && RST_PIN_IN &&
     !(BRK_REQ && !s_r.brk_d)) |=> STACK_START ##1 !STACK_START;
  endproperty
  a_wait_wake: assert property (p_wait_wake)
    else $error("wait wake did not stack");

  property p_wait_clk;
    s_r.mode == MODE_WAIT |-> !CPU_CLK_EN && PERIPH_CLK_EN;
  endproperty
  a_wait_clk: assert property (p_wait_clk)
    else $error("wait clock gating wrong");

  property p_stop_clk;
    s_r.mode == MODE_STOP |-> !XTAL_CLK_EN && !CPU_CLK_EN &&
                              s_r.cnt == CNT_ZERO;
  endproperty
  a_stop_clk: assert property (p_stop_clk)
    else $error("stop left clocks or counter running");

  property p_short_recover;
    (s_r.mode == MODE_STOP && $past(s_r.mode) == MODE_STOP &&
     SHORT_STOP_RECOVERY && |s_r.pend) ##1
    (s_r.mode == MODE_RECOVER && !(|RST_SRC) && RST_PIN_IN &&
     SHORT_STOP_RECOVERY)[*8] |-> !STACK_START;
  endproperty
  a_short_recover: assert property (p_short_recover)
    else $error("stacked before recovery ended");

  property p_clear_read;
    (RD && ADDR == OFF_RST_CAUSE && !(|RST_SRC) && RST_PIN_IN &&
     s_r.mode == MODE_RUN) |=> s_r.cause == BYTE_ZERO;
  endproperty
  a_clear_read: assert property (p_clear_read)
    else $error("cause register not cleared by read");

  property p_protect;
    BREAK_STATE && !s_r.clr_en |-> !FLAG_CLEAR_ALLOW;
  endproperty
  a_protect: assert property (p_protect)
    else $error("flag clear allowed in protected break");

  property p_imask;
    (s_r.mode == MODE_RUN && WAIT_EXEC && !(|RST_SRC) && RST_PIN_IN &&
     !(BRK_REQ && !s_r.brk_d)) |=> CLEAR_IMASK && !CPU_CLK_EN;
  endproperty
  a_imask: assert property (p_imask)
    else $error("wait did not clear mask");

  c_wait_wake: cover property (s_r.mode == MODE_WAIT ##1 STACK_START);
  c_stop_exit: cover property (s_r.mode == MODE_RECOVER ##1 STACK_START);
  c_brk_wait: cover property (s_r.mode == MODE_WAIT ##1 s_r.brk_woke);
  c_pin_flag: cover property (s_r.mode == MODE_RST_SAMPLE ##1
                              s_r.cause[BIT_PIN]);

endmodule : siu_core

// File: test/siu_partner.sv
/*
  siu_partner: stand-in for the board and one peripheral of the system
  integration unit: the open-drain reset wire with its pull-up, and one
  status flag with a two-step clear that obeys the clear permission.
  Assumes all controls are synchronous to sys_clk.
*/
module siu_partner
(
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic pin_oe_n,
  input wire logic pin_out,
  input wire logic ext_low,
  input wire logic clear_allow,
  input wire logic set_flag,
  input wire logic step1,
  input wire logic step2,
  output logic pin_level,
  output logic flag
);
  timeunit 1ns;
  timeprecision 1ps;

  logic armed; // first clear step seen

  // wire level: device pull-down wins, else external button, else pull-up
  assign pin_level = !pin_oe_n ? pin_out : !ext_low;

  // flag keeps its first step across break, clears only when allowed
  always_ff @(posedge sys_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      flag <= 1'h0;
      armed <= 1'h0;
    end
    else if (set_flag)
      flag <= 1'h1;
    else if (step1 && flag)
      armed <= 1'h1;
    else if (step2 && armed && clear_allow)
    begin
      flag <= 1'h0;
      armed <= 1'h0;
    end
  end
endmodule : siu_partner

// File: test/siu_core_bench.sv
/*
  siu_core_bench: self-checking bench for siu_core, driving the register
  port, cpu events and reset sources, with siu_partner on the reset wire.
  Assumes the hand-over timing: read data in the cycle after the strobe,
  outputs registered, 64-cycle reset sequence after any reset.
*/
module siu_core_bench
  import siu_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  logic sys_clk = 1'h0;
  logic arst_n = 1'h0;
  logic [15:0] addr = 16'h0000;
  logic [7:0] wdata = 8'h00;
  logic wr = 1'h0, rd = 1'h0, brk = 1'h0, emu = 1'h0, wd_dis = 1'h0;
  logic wait_x = 1'h0, stop_x = 1'h0, short_rec = 1'h1;
  logic mon_blank = 1'h0, irq_high = 1'h0, ext_low = 1'h0;
  logic set_f = 1'h0, st1 = 1'h0, st2 = 1'h0;
  logic [24:1] irq_flags = 24'h000000, irq_en = 24'h000000, f, p;
  siu_rst_src_s rst_src = 5'h00;
  logic [7:0] rdata;
  logic pin_lvl, pflag, pin_out, pin_oe_n, sys_reset, cpu_en, per_en;
  logic xtal_en, clr_im, stack, soft_irq, brk_st, allow, wd_run;
  int errors = 0, samples_checked = 0, cycles = 0, n;

  always #25 sys_clk = ~sys_clk;

  siu_core i_dut (.SYS_CLK(sys_clk), .ARST_N(arst_n), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .IRQ_FLAGS(irq_flags),
    .IRQ_ENABLES(irq_en), .BRK_REQ(brk), .WAIT_EXEC(wait_x),
    .STOP_EXEC(stop_x), .EMU_MODE(emu), .WDOG_DISABLE(wd_dis),
    .SHORT_STOP_RECOVERY(short_rec), .RST_SRC(rst_src),
    .MON_VEC_BLANK(mon_blank), .IRQ_PIN_HIGH(irq_high),
    .RST_PIN_IN(pin_lvl), .RST_PIN_OUT(pin_out), .RST_PIN_OE_N(pin_oe_n),
    .SYS_RESET(sys_reset), .CPU_CLK_EN(cpu_en), .PERIPH_CLK_EN(per_en),
    .XTAL_CLK_EN(xtal_en), .CLEAR_IMASK(clr_im), .STACK_START(stack),
    .VECTOR_SOFT_IRQ(soft_irq), .BREAK_STATE(brk_st),
    .FLAG_CLEAR_ALLOW(allow), .WDOG_RUN(wd_run));

  siu_partner i_partner (.sys_clk(sys_clk), .arst_n(arst_n),
    .pin_oe_n(pin_oe_n), .pin_out(pin_out), .ext_low(ext_low),
    .clear_allow(allow), .set_flag(set_f), .step1(st1), .step2(st2),
    .pin_level(pin_lvl), .flag(pflag));

  // one-cycle pulses drop on their own, so callers never assign twice
  always @(posedge sys_clk)
  begin
    if (wait_x) wait_x <= 1'h0;
    if (stop_x) stop_x <= 1'h0;
    if (rst_src != 5'h00) rst_src <= 5'h00;
    if (set_f) set_f <= 1'h0;
    if (st1) st1 <= 1'h0;
    if (st2) st2 <= 1'h0;
  end

  // hang guard, well above the longest recovery
  always @(posedge sys_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      errors++;
      print_verdict();
    end
  end

  task print_verdict();
    $display("checks %0d errors %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : print_verdict

  // value compare, four-state exact
  task chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // cycle count compare against a window
  task chk_cnt(input int got, input int lo, input int hi);
    samples_checked++;
    if (got < lo || got > hi)
    begin
      errors++;
      $display("ERROR t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
    end
  endtask : chk_cnt

  task wreg(input logic [15:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    addr <= a;
    wdata <= d;
    wr <= 1'h1;
    @(posedge sys_clk);
    wr <= 1'h0;
  endtask : wreg

  // read data stands only in the cycle after the strobe
  task rreg(input logic [15:0] a, input logic [7:0] exp);
    @(posedge sys_clk);
    addr <= a;
    rd <= 1'h1;
    @(posedge sys_clk);
    rd <= 1'h0;
    @(negedge sys_clk);
    chk(rdata, exp);
  endtask : rreg

  function automatic logic hit(input int w);
    case (w)
      0: hit = (sys_reset === 1'h0);
      1: hit = (stack === 1'h1);
      default: hit = (soft_irq === 1'h1);
    endcase
  endfunction : hit

  // counts falling edges until the event, bounded
  task wait_evt(input int w, output int k);
    k = 0;
    do
    begin
      @(negedge sys_clk);
      k++;
    end
    while (!hit(w) && k < 5000);
  endtask : wait_evt

  initial
  begin
    repeat (4) @(posedge sys_clk);
    chk({pin_oe_n, pin_out}, 2'h0);
    chk(sys_reset, 1'h1);
    arst_n <= 1'h1;
    wait_evt(0, n);
    chk_cnt(n, 64, 66);
    rreg(OFF_RST_CAUSE, RST_CAUSE_POR);
    rreg(OFF_RST_CAUSE, BYTE_ZERO);
    wreg(OFF_RST_CAUSE, 8'hFF);
    rreg(OFF_RST_CAUSE, BYTE_ZERO);
    // pending view, two complementary patterns
    for (int i = 0; i < 2; i++)
    begin
      f = i ? ~24'hA5C3F6 : 24'hA5C3F6;
      p = f & 24'h6F5AFF;
      @(posedge sys_clk);
      irq_flags <= f;
      irq_en <= 24'h6F5AFF;
      rreg(OFF_IRQ_LOW, {p[6:1], 2'h0});
      rreg(OFF_IRQ_MID, p[14:7]);
      rreg(OFF_IRQ_UPPER, p[22:15]);
      rreg(OFF_IRQ_TOP, {6'h00, p[24:23]});
      wreg(OFF_IRQ_MID, ~p[14:7]);
      rreg(OFF_IRQ_MID, p[14:7]);
    end
    rreg(16'hFE02, BYTE_ZERO);
    @(posedge sys_clk);
    irq_flags <= 24'h000000;
    irq_en <= 24'hFFFFFF;
    // protected two-step clear across break
    set_f <= 1'h1;
    @(posedge sys_clk);
    st1 <= 1'h1;
    @(posedge sys_clk);
    brk <= 1'h1;
    wait_evt(2, n);
    chk_cnt(n, 2, 2);
    @(negedge sys_clk);
    chk(allow, 1'h0);
    @(posedge sys_clk);
    st2 <= 1'h1;
    repeat (2) @(negedge sys_clk);
    chk(pflag, 1'h1);
    @(posedge sys_clk);
    brk <= 1'h0;
    repeat (3) @(negedge sys_clk);
    chk(allow, 1'h1);
    @(posedge sys_clk);
    st2 <= 1'h1;
    repeat (2) @(negedge sys_clk);
    chk(pflag, 1'h0);
    // clearing enabled in break sticks after exit
    wreg(OFF_BRK_CTRL, 8'h80);
    rreg(OFF_BRK_CTRL, 8'h80);
    @(posedge sys_clk);
    set_f <= 1'h1;
    brk <= 1'h1;
    repeat (3) @(negedge sys_clk);
    chk({brk_st, allow}, 2'h3);
    @(posedge sys_clk);
    st1 <= 1'h1;
    @(posedge sys_clk);
    st2 <= 1'h1;
    @(posedge sys_clk);
    brk <= 1'h0;
    repeat (3) @(negedge sys_clk);
    chk(pflag, 1'h0);
    wreg(OFF_BRK_CTRL, 8'h00);
    // wait, woken by an interrupt
    @(posedge sys_clk);
    wait_x <= 1'h1;
    repeat (2) @(negedge sys_clk);
    chk({clr_im, cpu_en, per_en}, 3'h5);
    chk(wd_run, 1'h1);
    @(posedge sys_clk);
    irq_flags[9] <= 1'h1;
    wait_evt(1, n);
    chk_cnt(n, 3, 3);
    @(posedge sys_clk);
    irq_flags <= 24'h000000;
    // wait with watchdog off, left by break
    @(posedge sys_clk);
    wd_dis <= 1'h1;
    emu <= 1'h1;
    wait_x <= 1'h1;
    repeat (2) @(negedge sys_clk);
    chk(wd_run, 1'h0);
    @(posedge sys_clk);
    brk <= 1'h1;
    wait_evt(2, n);
    chk_cnt(n, 2, 2);
    @(posedge sys_clk);
    brk <= 1'h0;
    wd_dis <= 1'h0;
    rreg(OFF_BRK_STATUS, 8'h02);
    @(posedge sys_clk);
    emu <= 1'h0;
    rreg(OFF_BRK_STATUS, BYTE_ZERO);
    // stop with short then long recovery
    for (int i = 0; i < 2; i++)
    begin
      @(posedge sys_clk);
      short_rec <= (i == 0);
      stop_x <= 1'h1;
      repeat (2) @(negedge sys_clk);
      chk({xtal_en, per_en, cpu_en, clr_im}, 4'h1);
      @(posedge sys_clk);
      irq_flags[3] <= 1'h1;
      wait_evt(1, n);
      chk_cnt(n, (i ? 4096 : 32) + 2, (i ? 4096 : 32) + 4);
      @(posedge sys_clk);
      irq_flags <= 24'h000000;
    end
    // every internal reset source, the first one while waiting with a request
    @(posedge sys_clk);
    wait_x <= 1'h1;
    mon_blank <= 1'h1;
    irq_high <= 1'h1;
    for (int k = 0; k < 5; k++)
    begin
      @(posedge sys_clk);
      rst_src <= siu_rst_src_s'(5'h10 >> k);
      irq_flags[9] <= 1'h1;
      repeat (2) @(negedge sys_clk);
      chk({sys_reset, stack}, 2'h2);
      wait_evt(0, n);
      chk_cnt(n, 60, 66);
      rreg(OFF_RST_CAUSE, 8'h20 >> k);
    end
    // external pin pulled low by the outside world
    @(posedge sys_clk);
    irq_flags <= 24'h000000;
    ext_low <= 1'h1;
    repeat (2) @(posedge sys_clk);
    ext_low <= 1'h0;
    repeat (2) @(negedge sys_clk);
    chk(pin_oe_n, 1'h0);
    wait_evt(0, n);
    chk_cnt(n, 60, 66);
    rreg(OFF_RST_CAUSE, 8'h40);
    print_verdict();
  end
endmodule : siu_core_bench
